// >>> rst_seq_defines.svh
// Purpose: constants for the reset and protected-ROM verify sequencer
// Assumes: one phase equals one oscillator period; twelve phases form a machine cycle
// Notes: strap levels are chosen values and may be changed to suit a tester
`ifndef RST_SEQ_DEFINES_SVH
`define RST_SEQ_DEFINES_SVH

// clock of the sequencing logic
`define CLK_MHZ 250
// machine cycle framing, in oscillator periods
`define OSC_PER_MCYCLE 12
`define PH_LAST 4'hb
`define PH_RST_SAMPLE 4'h9
`define PH_ALE_RISE_PREV 4'hb
`define PH_ALE_FALL_PREV 4'h1
`define VER_SAMPLE_CLP 3
`define PH_VER_SAMPLE_PREV 4'h2
`define PH_PROGRAM_STORE_STROBE_FALL_PREV 4'h3
`define PH_PROGRAM_STORE_STROBE_RISE_PREV 4'h5
// reset input must stay low this many oscillator periods
`define RST_MIN_OSC 24
`define RST_MIN_MCYCLES 2'h2
// oscillator watchdog
`define RC_FAIL_TICKS 2'h2
`define OWD_STAB_RC 768
`define OWD_STAB_LAST 10'h2ff
// protected ROM verify
`define ROM_LAST_ADDR 14'h3fff
`define GROUP_LAST 4'hf
`define FETCH_RESET_ADDR 16'h0000
// reset contents of port latches
`define PORT_RESET 8'hff
`define PORT2_RESET_EA_LOW 8'h00
// strap levels that select protected-ROM verify
`define VER_PROGRAM_STORE_STROBE_LVL 1'b0
`define VER_EA_LVL 1'b0
`define VER_ALE_LVL 1'b0

`endif

// >>> rst_seq_pkg.sv
// Purpose: types shared by the reset and protected-ROM verify sequencer
// Assumes: nothing beyond the defines header
// Notes: port latch group travels as one packed struct
package rst_seq_pkg;

    typedef enum logic [2:0] {
        ST_RESET  = 3'b000,
        ST_RUN    = 3'b001,
        ST_VERIFY = 3'b010,
        ST_VDONE  = 3'b011
    } seq_e;

    typedef struct packed {
        logic [7:0] p1;
        logic [7:0] p2;
        logic [7:0] p3;
        logic [7:0] p4;
        logic [7:0] p5;
        logic [7:0] p6;
    } port_out_s;

endpackage : rst_seq_pkg

// >>> pin_sync.sv
// Purpose: two-flop synchroniser with rising-edge pulse for a group of pins
// Assumes: inputs are asynchronous to clk
// Notes: stage one feeds stage two only
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // pins
    input wire logic [WIDTH-1:0] pin_in,
    // synchronised view
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    assign level = s2_r;
    assign rise = s2_r & ~s3_r;
endmodule : pin_sync

// >>> reset_and_rom_verify_sequencer.sv
// Purpose: reset sequencing, oscillator watchdog and protected-ROM verify for the controller
// Assumes: oscillator and RC clocks arrive as pins and are sampled by clk
// Notes: internal RAM is outside this block and is never cleared by it
// Function
// - verify starts at reset release when the three strap pins sit at selecting levels
// - in verify, address-latch strobe pulses once every twelve oscillator periods
// - no address is driven in verify; first compared byte is for location 0000
// - each strobe after the first advances the internal ROM pointer by one
// - port 0 is sampled three phases after strobe rise and compared with ROM
// - any mismatch sets a sticky error held over the current group
// - after each sixteenth byte the group result drives the result pin, high pass
// - after the last ROM byte, program-store strobe pulses mark verify end
// - internal reset runs in second asserted machine cycle, repeating each cycle
// - strobe pins are inputs during reset; outside must not drive them
// - instruction fetch begins at address 0000 after reset
// - reset loads ports 0, 1 and 3 to 6 latches with all ones
// - after reset port 2 follows the external-access select level
// - ports 7 and 8 read the pin levels, regardless of writes
// - reset leaves internal RAM contents alone
// - RC faster than oscillator flags failure, clocks chip from RC, holds reset
// - after oscillator runs, reset holds for 768 RC cycles, then switches clock
// - chip stays in reset until the external reset is also released
// - external reset clears watchdog status flag and ends power-down
`timescale 1ns/1ps
`include "rst_seq_defines.svh"
module reset_and_rom_verify_sequencer
    import rst_seq_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // clock source pins
    input wire logic osc_clk_pin,
    input wire logic rc_clk_pin,
    // reset and strap pins
    input wire logic reset_n_pin,
    input wire logic external_access_select_pin,
    // address-latch strobe pin
    input wire logic ale_in,
    output logic ale_out_r,
    output logic ale_oe_r,
    // program-store strobe pin, active low
    input wire logic program_store_strobe_n_in,
    output logic program_store_strobe_n_r,
    output logic program_store_strobe_oe_r,
    // port 0, open drain
    input wire logic [7:0] p0_in,
    output logic [7:0] p0_out_r,
    output logic [7:0] p0_oe_r,
    // ports 1 to 6 outputs, port 3 bit 5 carries the verify result
    output port_out_s ports_r,
    // input-only ports
    input wire logic [7:0] input_port_seven,
    input wire logic [3:0] input_port_eight,
    output logic [7:0] port7_read_r,
    output logic [3:0] port8_read_r,
    // internal ROM
    input wire logic [7:0] rom_data,
    output logic [13:0] rom_addr_r,
    // core side
    input wire logic power_down_req,
    input wire logic port_wr,
    input wire logic [2:0] port_wr_sel,
    input wire logic [7:0] port_wr_data,
    output logic [15:0] fetch_addr_r,
    output logic fetch_start_r,
    output logic chip_reset_r,
    output logic int_reset_pulse_r,
    output logic clk_sel_rc_r,
    output logic osc_watchdog_status_flag_r,
    output logic power_down_r,
    output logic verify_active_r,
    output logic verify_done_r
);
    localparam int SYNC_W = 26;

    logic [SYNC_W-1:0] sync_level;
    logic [SYNC_W-1:0] sync_rise;
    logic osc_rise;
    logic rc_rise;
    logic rst_n_s;
    logic ea_s;
    logic ale_s;
    logic program_store_strobe_n_s;
    logic [7:0] p0_s;
    logic [7:0] p7_s;
    logic [3:0] p8_s;

    pin_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin_in({osc_clk_pin, rc_clk_pin, reset_n_pin, external_access_select_pin, ale_in,
                 program_store_strobe_n_in, p0_in, input_port_seven, input_port_eight}),
        .level(sync_level),
        .rise(sync_rise)
    );

    assign osc_rise = sync_rise[25];
    assign rc_rise = sync_rise[24];
    assign rst_n_s = sync_level[23];
    assign ea_s = sync_level[22];
    assign ale_s = sync_level[21];
    assign program_store_strobe_n_s = sync_level[20];
    assign p0_s = sync_level[19:12];
    assign p7_s = sync_level[11:4];
    assign p8_s = sync_level[3:0];

    seq_e state_r;
    logic [3:0] ph_r;
    logic tick;
    logic rst_sample;
    logic [1:0] low_cnt_r;
    logic ext_rst_r;
    logic owd_rst_r;
    logic [1:0] rc_cnt_r;
    logic [9:0] stab_cnt_r;
    logic osc_fail;
    logic strap_ver_r;
    logic first_ale_r;
    logic [3:0] byte_cnt_r;
    logic err_r;
    logic cmp_tick;
    logic mismatch;
    logic group_end;
    logic last_cmp;
    logic chip_reset_nxt;
    logic [7:0] p0_latch_r;

    // chip phase clock follows the watchdog's chosen source
    assign tick = clk_sel_rc_r ? rc_rise : osc_rise;
    assign rst_sample = tick && (ph_r == `PH_RST_SAMPLE);
    assign chip_reset_nxt = ext_rst_r | owd_rst_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ph_r <= 4'h0;
        end else if (tick) begin
            ph_r <= (ph_r == `PH_LAST) ? 4'h0 : ph_r + 4'h1;
        end
    end

    // reset pin sampled once a machine cycle; acts from the second low sample
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            low_cnt_r <= 2'h0;
            ext_rst_r <= 1'b0;
            int_reset_pulse_r <= 1'b0;
        end else begin
            int_reset_pulse_r <= 1'b0;
            if (rst_sample) begin
                if (!rst_n_s) begin
                    if (low_cnt_r != `RST_MIN_MCYCLES) begin
                        low_cnt_r <= low_cnt_r + 2'h1;
                    end
                    if (low_cnt_r != 2'h0) begin
                        ext_rst_r <= 1'b1;
                        int_reset_pulse_r <= 1'b1;
                    end
                end else begin
                    low_cnt_r <= 2'h0;
                    ext_rst_r <= 1'b0;
                end
            end
        end
    end

    // oscillator watchdog: two RC edges without an oscillator edge means failure
    assign osc_fail = (rc_cnt_r == `RC_FAIL_TICKS);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rc_cnt_r <= `RC_FAIL_TICKS;
        end else if (osc_rise) begin
            rc_cnt_r <= 2'h0;
        end else if (rc_rise && !osc_fail) begin
            rc_cnt_r <= rc_cnt_r + 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            owd_rst_r <= 1'b1;
            clk_sel_rc_r <= 1'b1;
            stab_cnt_r <= 10'h000;
        end else if (osc_fail) begin
            owd_rst_r <= 1'b1;
            clk_sel_rc_r <= 1'b1;
            stab_cnt_r <= 10'h000;
        end else if (owd_rst_r && rc_rise) begin
            if (stab_cnt_r == `OWD_STAB_LAST) begin
                owd_rst_r <= 1'b0;
                clk_sel_rc_r <= 1'b0;
            end else begin
                stab_cnt_r <= stab_cnt_r + 10'h001;
            end
        end
    end

    // status and power-down flags: a new set wins over the reset clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            osc_watchdog_status_flag_r <= 1'b0;
            power_down_r <= 1'b0;
        end else begin
            osc_watchdog_status_flag_r <= osc_fail
                | (osc_watchdog_status_flag_r & ~int_reset_pulse_r);
            power_down_r <= power_down_req | (power_down_r & ~int_reset_pulse_r);
        end
    end

    // straps are caught while reset is held
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            strap_ver_r <= 1'b0;
        end else if (ext_rst_r && tick) begin
            strap_ver_r <= (program_store_strobe_n_s == `VER_PROGRAM_STORE_STROBE_LVL) && (ea_s == `VER_EA_LVL)
                && (ale_s == `VER_ALE_LVL);
        end
    end

    // sequencer
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= ST_RESET;
            chip_reset_r <= 1'b1;
            fetch_start_r <= 1'b0;
            fetch_addr_r <= `FETCH_RESET_ADDR;
            verify_active_r <= 1'b0;
            verify_done_r <= 1'b0;
        end else begin
            chip_reset_r <= chip_reset_nxt;
            fetch_start_r <= 1'b0;
            if (chip_reset_nxt) begin
                state_r <= ST_RESET;
                fetch_addr_r <= `FETCH_RESET_ADDR;
                verify_active_r <= 1'b0;
                verify_done_r <= 1'b0;
            end else begin
                case (state_r)
                    ST_RESET: begin
                        if (strap_ver_r) begin
                            state_r <= ST_VERIFY;
                            verify_active_r <= 1'b1;
                        end else begin
                            state_r <= ST_RUN;
                            fetch_start_r <= 1'b1;
                        end
                    end
                    ST_VERIFY: begin
                        if (last_cmp) begin
                            state_r <= ST_VDONE;
                            verify_active_r <= 1'b0;
                            verify_done_r <= 1'b1;
                        end
                    end
                    ST_VDONE: begin
                        state_r <= ST_VDONE;
                    end
                    default: begin
                        state_r <= ST_RUN;
                    end
                endcase
            end
        end
    end

    // strobe pins: inputs during reset, driven afterwards
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ale_out_r <= 1'b0;
            ale_oe_r <= 1'b0;
            program_store_strobe_n_r <= 1'b1;
            program_store_strobe_oe_r <= 1'b0;
        end else if (chip_reset_nxt || state_r == ST_RESET) begin
            ale_out_r <= 1'b0;
            ale_oe_r <= 1'b0;
            program_store_strobe_n_r <= 1'b1;
            program_store_strobe_oe_r <= 1'b0;
        end else begin
            ale_oe_r <= 1'b1;
            program_store_strobe_oe_r <= 1'b1;
            if (tick && ph_r == `PH_ALE_RISE_PREV) begin
                ale_out_r <= 1'b1;
            end else if (tick && ph_r == `PH_ALE_FALL_PREV) begin
                ale_out_r <= 1'b0;
            end
            if (state_r == ST_VDONE && tick && ph_r == `PH_PROGRAM_STORE_STROBE_FALL_PREV) begin
                program_store_strobe_n_r <= 1'b0;
            end else if (tick && ph_r == `PH_PROGRAM_STORE_STROBE_RISE_PREV) begin
                program_store_strobe_n_r <= 1'b1;
            end
        end
    end

    // verify compare, three phases after each strobe rise
    assign cmp_tick = (state_r == ST_VERIFY) && tick && (ph_r == `PH_VER_SAMPLE_PREV);
    assign mismatch = (p0_s != rom_data);
    assign group_end = cmp_tick && (byte_cnt_r == `GROUP_LAST);
    assign last_cmp = cmp_tick && (rom_addr_r == `ROM_LAST_ADDR);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rom_addr_r <= 14'h0000;
            first_ale_r <= 1'b1;
        end else if (state_r != ST_VERIFY) begin
            rom_addr_r <= 14'h0000;
            first_ale_r <= 1'b1;
        end else if (tick && ph_r == `PH_ALE_RISE_PREV) begin
            first_ale_r <= 1'b0;
            if (!first_ale_r && rom_addr_r != `ROM_LAST_ADDR) begin
                rom_addr_r <= rom_addr_r + 14'h0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            byte_cnt_r <= 4'h0;
            err_r <= 1'b0;
        end else if (state_r != ST_VERIFY) begin
            byte_cnt_r <= 4'h0;
            err_r <= 1'b0;
        end else if (cmp_tick) begin
            byte_cnt_r <= byte_cnt_r + 4'h1;
            if (group_end) begin
                err_r <= 1'b0;
            end else begin
                err_r <= err_r | mismatch;
            end
        end
    end

    // port latches; port 2 reset follows the access-select level
    always_ff @(posedge clk) begin
        if (sys_rst || chip_reset_nxt) begin
            p0_latch_r <= `PORT_RESET;
            ports_r.p1 <= `PORT_RESET;
            ports_r.p2 <= ea_s ? `PORT_RESET : `PORT2_RESET_EA_LOW;
            ports_r.p3 <= `PORT_RESET;
            ports_r.p4 <= `PORT_RESET;
            ports_r.p5 <= `PORT_RESET;
            ports_r.p6 <= `PORT_RESET;
        end else if (group_end) begin
            ports_r.p3[5] <= ~(err_r | mismatch);
        end else if (port_wr && state_r == ST_RUN) begin
            if (port_wr_sel == 3'h0) begin
                p0_latch_r <= port_wr_data;
            end else if (port_wr_sel == 3'h1) begin
                ports_r.p1 <= port_wr_data;
            end else if (port_wr_sel == 3'h2) begin
                ports_r.p2 <= port_wr_data;
            end else if (port_wr_sel == 3'h3) begin
                ports_r.p3 <= port_wr_data;
            end else if (port_wr_sel == 3'h4) begin
                ports_r.p4 <= port_wr_data;
            end else if (port_wr_sel == 3'h5) begin
                ports_r.p5 <= port_wr_data;
            end else if (port_wr_sel == 3'h6) begin
                ports_r.p6 <= port_wr_data;
            end
        end
    end

    // port 0 open drain: driven only for zero bits, never in verify
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            p0_out_r <= 8'h00;
            p0_oe_r <= 8'h00;
        end else if (state_r == ST_VERIFY || state_r == ST_VDONE || chip_reset_nxt) begin
            p0_out_r <= 8'h00;
            p0_oe_r <= 8'h00;
        end else begin
            p0_out_r <= 8'h00;
            p0_oe_r <= ~p0_latch_r;
        end
    end

    // input-only ports reflect the pins; writes have no path here
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            port7_read_r <= 8'h00;
            port8_read_r <= 4'h0;
        end else begin
            port7_read_r <= p7_s;
            port8_read_r <= p8_s;
        end
    end

    // RAM is held elsewhere and receives no clear from this block
endmodule : reset_and_rom_verify_sequencer

// >>> rst_seq_checker_sva.sv
// Purpose: concurrent checks on the reset and verify sequencer ports
// Assumes: one clock domain, sys_rst synchronous active high
// Notes: tick counting uses the raw oscillator pin, sync delay is constant
`timescale 1ns/1ps
`include "rst_seq_defines.svh"
module rst_seq_checker
    import rst_seq_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // pins
    input wire logic osc_clk_pin,
    input wire logic reset_n_pin,
    input wire logic external_access_select_pin,
    // watched outputs
    input wire logic ale_out_r,
    input wire logic program_store_strobe_n_r,
    input wire logic [7:0] p0_oe_r,
    input wire port_out_s ports_r,
    input wire logic [13:0] rom_addr_r,
    input wire logic [15:0] fetch_addr_r,
    input wire logic chip_reset_r,
    input wire logic int_reset_pulse_r,
    input wire logic clk_sel_rc_r,
    input wire logic verify_active_r,
    input wire logic verify_done_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    logic osc_q_r;
    logic ale_q_r;
    logic seen_r;
    logic [4:0] tick_cnt_r;
    wire osc_rise = osc_clk_pin && !osc_q_r;
    wire ale_rise = ale_out_r && !ale_q_r;

    always_ff @(posedge clk) begin
        osc_q_r <= osc_clk_pin;
        ale_q_r <= ale_out_r;
    end
    // oscillator rises seen since the last strobe rise
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tick_cnt_r <= 5'h00;
        end else begin
            tick_cnt_r <= (ale_rise ? 5'h00 : tick_cnt_r) + {4'h0, osc_rise};
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst || !verify_active_r) begin
            seen_r <= 1'b0;
        end else if (ale_rise) begin
            seen_r <= 1'b1;
        end
    end

    sequence ale_rise_s;
        $rose(ale_out_r) && verify_active_r;
    endsequence
    sequence addr_move_s;
        verify_active_r && $changed(rom_addr_r);
    endsequence
    sequence held_reset_s;
        chip_reset_r && $past(chip_reset_r);
    endsequence

    a_ale_period: assert property (ale_rise_s ##0 seen_r |-> tick_cnt_r == 5'h0c)
        else $error("strobe period is not twelve oscillator periods");
    a_addr_step: assert property (addr_move_s |-> rom_addr_r == 14'($past(rom_addr_r) + 1))
        else $error("rom pointer did not step by one");
    a_addr_on_ale: assert property (addr_move_s |-> ale_out_r)
        else $error("rom pointer moved outside a strobe pulse");
    a_no_p0_drive: assert property (verify_active_r || verify_done_r |-> p0_oe_r == 8'h00)
        else $error("port 0 driven during verify");
    a_group_result: assert property (verify_active_r && $changed(ports_r.p3[5])
        |-> rom_addr_r[3:0] == `GROUP_LAST)
        else $error("result pin changed inside a group");
    a_program_store_strobe_idle: assert property (verify_active_r |-> program_store_strobe_n_r)
        else $error("program store strobe pulsed before verify end");
    a_int_pulse_one: assert property (int_reset_pulse_r |=> !int_reset_pulse_r ##11 1)
        else $error("internal reset pulse longer than one cycle");
    a_int_in_reset: assert property (int_reset_pulse_r |-> chip_reset_r)
        else $error("internal reset pulse outside chip reset");
    a_rc_holds_reset: assert property (clk_sel_rc_r |-> chip_reset_r)
        else $error("running from rc clock without reset");
    a_ext_release: assert property ($fell(chip_reset_r) |-> reset_n_pin && !clk_sel_rc_r)
        else $error("chip reset released while a request holds");
    a_fetch_zero: assert property (chip_reset_r |-> fetch_addr_r == `FETCH_RESET_ADDR)
        else $error("fetch address not zero in reset");
    a_ports_ones: assert property (held_reset_s |=> ports_r.p1 == `PORT_RESET
        && ports_r.p3 == `PORT_RESET && ports_r.p6 == `PORT_RESET)
        else $error("port latches not all ones in reset");
    a_port2_ea: assert property (held_reset_s |=> ports_r.p2 ==
        (external_access_select_pin ? `PORT_RESET : `PORT2_RESET_EA_LOW))
        else $error("port 2 does not follow access select");
endmodule : rst_seq_checker

bind reset_and_rom_verify_sequencer rst_seq_checker i_rst_seq_checker (
    .clk(clk), .sys_rst(sys_rst), .osc_clk_pin(osc_clk_pin), .reset_n_pin(reset_n_pin),
    .external_access_select_pin(external_access_select_pin), .ale_out_r(ale_out_r),
    .program_store_strobe_n_r(program_store_strobe_n_r), .p0_oe_r(p0_oe_r),
    .ports_r(ports_r), .rom_addr_r(rom_addr_r), .fetch_addr_r(fetch_addr_r),
    .chip_reset_r(chip_reset_r), .int_reset_pulse_r(int_reset_pulse_r),
    .clk_sel_rc_r(clk_sel_rc_r), .verify_active_r(verify_active_r),
    .verify_done_r(verify_done_r)
);

// >>> verify_tester.sv
// Purpose: external verify tester and internal rom stand-in
// Assumes: rom contents are loaded by the bench before reset release
// Notes: odd groups get one corrupted byte at bad_pos
`timescale 1ns/1ps
module verify_tester (
    // clock
    input wire logic clk,
    // pins seen by the tester
    input wire logic reset_n_pin,
    input wire logic ale_pin,
    input wire logic [3:0] bad_pos,
    // rom port
    input wire logic [13:0] rom_addr,
    output logic [7:0] rom_data,
    // expected byte for port 0
    output logic [7:0] p0_drive,
    output logic [13:0] byte_idx
);
    logic [7:0] rom [256];
    logic ale_q_r;
    logic first_r;

    always_ff @(posedge clk) begin
        ale_q_r <= ale_pin;
        if (!reset_n_pin) begin
            byte_idx <= 14'h0000;
            first_r <= 1'b1;
        end else if (ale_pin && !ale_q_r) begin
            first_r <= 1'b0;
            if (!first_r) begin
                byte_idx <= byte_idx + 14'h0001;
            end
        end
    end
    assign rom_data = rom[rom_addr[7:0]];
    assign p0_drive = rom[byte_idx[7:0]]
        ^ ((byte_idx[4] && byte_idx[3:0] == bad_pos) ? 8'h5a : 8'h00);
endmodule : verify_tester

// >>> test_reset_and_rom_verify_sequencer.sv
// Purpose: self-checking bench for reset, watchdog and protected verify
// Assumes: osc period 4 clk, rc period 6 clk, straps at verify levels
// Notes: full rom sweep is too long, only the first groups are run
`timescale 1ns/1ps
`include "rst_seq_defines.svh"
module test_reset_and_rom_verify_sequencer;
    import rst_seq_pkg::*;
    logic clk = 0, sys_rst = 1, osc = 0, rc = 0, osc_run = 0, reset_n = 0, ea = 0;
    logic ale_out, ale_oe, program_store_strobe_n, program_store_strobe_oe, rom_data_w, pd_req = 0, port_wr = 0;
    logic fetch_start, chip_reset, int_pulse, clk_sel, owd_flag, pd, vact, vdone;
    logic [7:0] p0_out, p0_oe, p0_drive, rom_data, p7 = 0, p7r;
    logic [3:0] p8 = 0, p8r, bad_pos = 0;
    logic [2:0] port_wr_sel = 0;
    logic [7:0] port_wr_data = 0;
    logic [13:0] rom_addr, byte_idx;
    logic [15:0] fetch_addr;
    port_out_s ports;
    int mismatches = 0, check_count = 0, n;
    wire ale_pin = ale_oe ? ale_out : `VER_ALE_LVL;
    wire program_store_strobe_pin = program_store_strobe_oe ? program_store_strobe_n : `VER_PROGRAM_STORE_STROBE_LVL;

    always #2 clk = ~clk;
    always #8 if (osc_run) osc = ~osc;
    always #12 rc = ~rc;

    reset_and_rom_verify_sequencer i_reset_and_rom_verify_sequencer (
        .clk(clk), .sys_rst(sys_rst), .osc_clk_pin(osc), .rc_clk_pin(rc),
        .reset_n_pin(reset_n), .external_access_select_pin(ea), .ale_in(ale_pin),
        .ale_out_r(ale_out), .ale_oe_r(ale_oe), .program_store_strobe_n_in(program_store_strobe_pin),
        .program_store_strobe_n_r(program_store_strobe_n), .program_store_strobe_oe_r(program_store_strobe_oe),
        .p0_in(p0_drive & ~p0_oe), .p0_out_r(p0_out), .p0_oe_r(p0_oe), .ports_r(ports),
        .input_port_seven(p7), .input_port_eight(p8), .port7_read_r(p7r),
        .port8_read_r(p8r), .rom_data(rom_data), .rom_addr_r(rom_addr),
        .power_down_req(pd_req), .port_wr(port_wr), .port_wr_sel(port_wr_sel),
        .port_wr_data(port_wr_data), .fetch_addr_r(fetch_addr), .fetch_start_r(fetch_start),
        .chip_reset_r(chip_reset), .int_reset_pulse_r(int_pulse), .clk_sel_rc_r(clk_sel),
        .osc_watchdog_status_flag_r(owd_flag), .power_down_r(pd),
        .verify_active_r(vact), .verify_done_r(vdone)
    );
    verify_tester i_verify_tester (
        .clk(clk), .reset_n_pin(reset_n), .ale_pin(ale_pin), .bad_pos(bad_pos),
        .rom_addr(rom_addr), .rom_data(rom_data), .p0_drive(p0_drive), .byte_idx(byte_idx)
    );

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim
    // group g-1 passes unless it is odd, group 0 shows the reset level
    function automatic logic exp_result(input int g);
        return (g == 0) || ((g - 1) % 2 == 0);
    endfunction : exp_result

    initial begin
        #400000;
        mismatches++;
        end_sim();
    end
    initial begin
        void'($urandom(32'h89b4df81));
        for (int k = 0; k < 256; k++) i_verify_tester.rom[k] = 8'($urandom);
        bad_pos = 4'(2 + $urandom % 12);
        repeat (4) @(posedge clk);
        #1 sys_rst = 0;
        repeat (40) @(posedge clk);
        #1 chk(48'({clk_sel, owd_flag, chip_reset}), 48'h7);
        osc_run = 1;
        for (n = 0; n < 6000 && clk_sel !== 1'b0; n++) @(posedge clk);
        #1 chk(48'(clk_sel), 48'h0);
        repeat (60) @(posedge clk);
        #1 chk(48'(chip_reset), 48'h1);
        chk(48'(owd_flag), 48'h0);
        chk(ports, {8'hff, `PORT2_RESET_EA_LOW, {4{8'hff}}});
        chk(48'({p0_oe, ale_oe, program_store_strobe_oe}), 48'h0);
        chk(48'(fetch_addr), 48'(`FETCH_RESET_ADDR));
        pd_req = 1;
        @(posedge clk);
        #1 pd_req = 0;
        repeat (100) @(posedge clk);
        #1 chk(48'(pd), 48'h0);
        n = 0;
        repeat (96) begin
            @(posedge clk);
            #1 n += int'(int_pulse);
        end
        chk(48'(n), 48'd2);
        p7 = 8'($urandom);
        p8 = 4'($urandom);
        repeat (6) @(posedge clk);
        #1 chk(48'({p7r, p8r}), 48'({p7, p8}));
        reset_n = 1;
        for (n = 0; n < 200 && vact !== 1'b1; n++) @(posedge clk);
        #1 chk(48'(vact), 48'h1);
        for (int g = 0; g < 9; g++) begin
            for (n = 0; n < 1000 && byte_idx !== 14'(16 * g + 8); n++) @(posedge clk);
            #1 chk(48'(ports.p3[5]), 48'(exp_result(g)));
            port_wr_sel = 3'h1;
            port_wr_data = 8'($urandom);
            port_wr = 1;
            @(posedge clk);
            #1 port_wr = 0;
            repeat (3) @(posedge clk);
            #1 chk(48'(ports.p1), 48'(`PORT_RESET));
        end
        chk(48'({program_store_strobe_n, fetch_addr}), 48'h10000);
        end_sim();
    end
endmodule : test_reset_and_rom_verify_sequencer
